// ### logic/servo_status_word_packer.v
// Purpose: Packs warning bytes and logical I/O monitor words for the host
// Assumes: Flag inputs are asynchronous levels; positions share sys_clk_in
// Notes:   Registers on a plain strobe port, read data one cycle later
//
// Notes on behaviour
// [R1] Bytes 12,13 carry overload, fan, regen, battery, power, counter, comm
// [R2] Byte 14 bits 4..0 carry scale, oscillation, encoder, lifetime flags
// [R3] Servo off, velocity or torque mode: command position tracks motor
// [R4] Deviation undefined in those states; host must not rely on it
// [R5] Input word: bit7 e-stop, 3/2 inhibits, 0 servo-on, 28/27 safety
// [R6] Input bit 0 is the internal servo-on command, not the pin
// [R7] Extended input: bit4 near home, 2..0 latches, 22..18 monitors
// [R8] Output low half: bits 6..0 status, bit 9 speed_reached_in, bit 15
// [R9] Output bits 23..16 status flags, 25..24 network operation outputs
// [R10] Output bit 15 reads 0 with servo on, 1 with servo off
// [R11] Extended output: bit 9 link synchronisation complete
// [R12] All unused bit positions read as zero
`timescale 1ns/1ps
`include "status_packer_defines.vh"
module servo_status_word_packer #(
    parameter POS_W = 32
) (
    input  wire              sys_clk_in,
    input  wire              reset_n_in,
    input  wire [`ADDR_W-1:0] addr_in,
    input  wire [31:0]       wr_data_in,
    input  wire              wr_en_in,
    input  wire              rd_en_in,
    output reg  [31:0]       rd_data_out,
    output reg               irq_out,
    output reg               servo_on_cmd_out,
    output reg  [POS_W-1:0]  cmd_position_out,
    input  wire [3:0]        warn_byte12_in,
    input  wire [4:0]        warn_byte13_in,
    input  wire [4:0]        warn_byte14_in,
    input  wire              estop_in,
    input  wire              positive_drive_inhibit_in,
    input  wire              negative_drive_inhibit_in,
    input  wire              safety_in_one_in,
    input  wire              safety_in_two_in,
    input  wire              near_home_in,
    input  wire [2:0]        latch_in,
    input  wire [4:0]        gp_monitor_in,
    input  wire [6:0]        out_low_in,
    input  wire              speed_reached_in,
    input  wire [7:0]        out_high_in,
    input  wire [1:0]        net_operation_in,
    input  wire              link_sync_done_in,
    input  wire [POS_W-1:0]  actual_position_in
);
    localparam SYNC_W = 4 + 5 + 5 + 5 + 1 + 3 + 5 + 7 + 1 + 8 + 2 + 1;

    wire [SYNC_W-1:0] raw_flags;
    wire [SYNC_W-1:0] sync_flags;

    wire [3:0] w12;
    wire [4:0] w13;
    wire [4:0] w14;
    wire       estop_s;
    wire       pos_inh_s;
    wire       neg_inh_s;
    wire       safety_one_s;
    wire       safety_two_s;
    wire       near_home_s;
    wire [2:0] latch_s;
    wire [4:0] gp_mon_s;
    wire [6:0] out_low_s;
    wire       speed_reached_s;
    wire [7:0] out_high_s;
    wire [1:0] net_op_s;
    wire       sync_done_s;

    reg  [POS_W-1:0] host_pos_reg;
    reg  [2:0]       ctrl_reg;
    reg  [POS_W-1:0] deviation_reg;
    reg  [31:0]      warn_word_reg;
    reg  [31:0]      lin_word_reg;
    reg  [31:0]      lin_ext_word_reg;
    reg  [31:0]      lout_word_reg;
    reg  [31:0]      lout_ext_word_reg;
    reg  [`IRQ_W-1:0] irq_stat_reg;
    reg  [`IRQ_W-1:0] irq_stat_next;
    reg  [`IRQ_W-1:0] irq_mask_reg;
    reg  [`IRQ_W-1:0] irq_event;
    reg  [31:0]      warn_word_next;
    reg  [31:0]      lin_word_next;
    reg  [31:0]      lin_ext_word_next;
    reg  [31:0]      lout_word_next;
    reg  [31:0]      lout_ext_word_next;
    reg  [31:0]      rd_data_next;

    wire [1:0] mode;
    wire       servo_on_int;
    wire       follow_actual;

    assign raw_flags = {warn_byte12_in, warn_byte13_in, warn_byte14_in,
                        estop_in, positive_drive_inhibit_in,
                        negative_drive_inhibit_in, safety_in_one_in,
                        safety_in_two_in, near_home_in, latch_in,
                        gp_monitor_in, out_low_in, speed_reached_in,
                        out_high_in, net_operation_in, link_sync_done_in};

    // Pins change at any time, so every flag is resampled
    bit_sync #(
        .WIDTH      (SYNC_W)
    ) u_flag_sync (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (raw_flags),
        .sync_out   (sync_flags)
    );

    assign {w12, w13, w14, estop_s, pos_inh_s, neg_inh_s, safety_one_s,
            safety_two_s, near_home_s, latch_s, gp_mon_s, out_low_s,
            speed_reached_s, out_high_s, net_op_s, sync_done_s} = sync_flags;

    assign mode = ctrl_reg[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];

    // [R6] Internal servo-on command
    assign servo_on_int = ctrl_reg[`CTRL_SERVO_ON] & ~estop_s;

    // [R3] Follow condition
    assign follow_actual = ~servo_on_int | (mode == `MODE_VELOCITY) |
                           (mode == `MODE_TORQUE);

    always @* begin
        // [R12] Unused bits zero
        warn_word_next = `ZERO32;
        // [R1] Bytes 12 and 13
        warn_word_next[`WB_OVERLOAD]  = w12[3];
        warn_word_next[`WB_FAN_LOCK]  = w12[2];
        warn_word_next[`WB_REGEN]     = w12[1];
        warn_word_next[`WB_BATTERY]   = w12[0];
        warn_word_next[`WB_MAIN_OFF]  = w13[4];
        warn_word_next[`WB_UPD_CNT]   = w13[3];
        warn_word_next[`WB_CUM_COMM]  = w13[2];
        warn_word_next[`WB_CONT_COMM] = w13[1];
        warn_word_next[`WB_SCALE_ERR] = w13[0];
        // [R2] Byte 14 flags
        warn_word_next[`WB_SCALE_COMM] = w14[4];
        warn_word_next[`WB_OSC_DET]    = w14[3];
        warn_word_next[`WB_ENC_COMM]   = w14[2];
        warn_word_next[`WB_ENC_HOT]    = w14[1];
        warn_word_next[`WB_LIFETIME]   = w14[0];

        lin_word_next = `ZERO32;
        // [R5] Input word
        lin_word_next[`LI_ESTOP]       = estop_s;
        lin_word_next[`LI_POS_INHIBIT] = pos_inh_s;
        lin_word_next[`LI_NEG_INHIBIT] = neg_inh_s;
        lin_word_next[`LI_SAFETY_TWO]  = safety_two_s;
        lin_word_next[`LI_SAFETY_ONE]  = safety_one_s;
        // [R6] Command, not pin
        lin_word_next[`LI_SERVO_ON]    = servo_on_int;

        lin_ext_word_next = `ZERO32;
        // [R7] Extended inputs
        lin_ext_word_next[`LX_NEAR_HOME] = near_home_s;
        lin_ext_word_next[`LX_LATCH_LSB+2:`LX_LATCH_LSB] = latch_s;
        lin_ext_word_next[`LX_GP_MON_LSB+4:`LX_GP_MON_LSB] = gp_mon_s;

        lout_word_next = `ZERO32;
        // [R8] Low half
        lout_word_next[`LO_LOW_LSB+6:`LO_LOW_LSB] = out_low_s;
        lout_word_next[`LO_SPEED_REACHED]         = speed_reached_s;
        // [R10] Active low servo state
        lout_word_next[`LO_SERVO_ON_N]            = ~servo_on_int;
        // [R9] Upper status flags
        lout_word_next[`LO_HIGH_LSB+7:`LO_HIGH_LSB]     = out_high_s;
        lout_word_next[`LO_NET_OP_LSB+1:`LO_NET_OP_LSB] = net_op_s;

        lout_ext_word_next = `ZERO32;
        // [R11] Sync complete
        lout_ext_word_next[`LOX_SYNC_DONE] = sync_done_s;
    end

    // Events compare against the previous snapshot
    always @* begin
        irq_event = {`IRQ_W{1'b0}};
        irq_event[`IRQ_WARN] = |(warn_word_next & ~warn_word_reg);
        irq_event[`IRQ_ALARM] = out_low_s[1] & ~lout_word_reg[1];
        irq_event[`IRQ_SYNC_LOST] = ~sync_done_s &
                                    lout_ext_word_reg[`LOX_SYNC_DONE];
        irq_event[`IRQ_INHIBIT] =
            (pos_inh_s & ~lin_word_reg[`LI_POS_INHIBIT]) |
            (neg_inh_s & ~lin_word_reg[`LI_NEG_INHIBIT]);
        irq_stat_next = irq_stat_reg;
        if (rd_en_in && addr_in == `OFS_IRQ_STAT) begin
            irq_stat_next = {`IRQ_W{1'b0}};
        end
        // Set wins over the read clear
        irq_stat_next = irq_stat_next | irq_event;
    end

    always @* begin
        rd_data_next = `ZERO32;
        case (addr_in)
            `OFS_WARN:      rd_data_next = warn_word_reg;
            `OFS_LIN:       rd_data_next = lin_word_reg;
            `OFS_LIN_EXT:   rd_data_next = lin_ext_word_reg;
            `OFS_LOUT:      rd_data_next = lout_word_reg;
            `OFS_LOUT_EXT:  rd_data_next = lout_ext_word_reg;
            `OFS_HOST_POS:  rd_data_next[POS_W-1:0] = host_pos_reg;
            `OFS_CMD_POS:   rd_data_next[POS_W-1:0] = cmd_position_out;
            `OFS_DEVIATION: rd_data_next[POS_W-1:0] = deviation_reg;
            `OFS_CTRL:      rd_data_next[2:0] = ctrl_reg;
            `OFS_IRQ_STAT:  rd_data_next[`IRQ_W-1:0] = irq_stat_reg;
            `OFS_IRQ_MASK:  rd_data_next[`IRQ_W-1:0] = irq_mask_reg;
            default:        rd_data_next = `ZERO32;
        endcase
    end

    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            host_pos_reg      <= {POS_W{1'b0}};
            ctrl_reg          <= `CTRL_RESET;
            irq_mask_reg      <= {`IRQ_W{1'b0}};
            irq_stat_reg      <= {`IRQ_W{1'b0}};
            irq_out           <= 1'b0;
            rd_data_out       <= `ZERO32;
            warn_word_reg     <= `ZERO32;
            lin_word_reg      <= `ZERO32;
            lin_ext_word_reg  <= `ZERO32;
            lout_word_reg     <= `ZERO32;
            lout_ext_word_reg <= `ZERO32;
            servo_on_cmd_out  <= 1'b0;
            cmd_position_out  <= {POS_W{1'b0}};
            deviation_reg     <= {POS_W{1'b0}};
        end else begin
            if (wr_en_in) begin
                case (addr_in)
                    `OFS_HOST_POS: host_pos_reg <= wr_data_in[POS_W-1:0];
                    `OFS_CTRL:     ctrl_reg     <= wr_data_in[2:0];
                    `OFS_IRQ_MASK: irq_mask_reg <= wr_data_in[`IRQ_W-1:0];
                    default:       ctrl_reg     <= ctrl_reg;
                endcase
            end
            irq_stat_reg      <= irq_stat_next;
            irq_out           <= |(irq_stat_next & irq_mask_reg);
            rd_data_out       <= rd_en_in ? rd_data_next : `ZERO32;
            warn_word_reg     <= warn_word_next;
            lin_word_reg      <= lin_word_next;
            lin_ext_word_reg  <= lin_ext_word_next;
            lout_word_reg     <= lout_word_next;
            lout_ext_word_reg <= lout_ext_word_next;
            servo_on_cmd_out  <= servo_on_int;
            // [R3] Track motor position
            if (follow_actual) begin
                cmd_position_out <= actual_position_in;
            end else begin
                cmd_position_out <= host_pos_reg;
            end
            // [R4] Deviation forced to zero when undefined
            if (follow_actual) begin
                deviation_reg <= {POS_W{1'b0}};
            end else begin
                deviation_reg <= host_pos_reg - actual_position_in;
            end
        end
    end
endmodule

// ### include/status_packer_defines.vh
// Purpose: Constants for the servo status word packer
// Assumes: Byte addresses on a 32-bit register port
// Notes:   Bit positions are within each 32-bit word
`ifndef STATUS_PACKER_DEFINES_VH
`define STATUS_PACKER_DEFINES_VH

`define ADDR_W           8
`define OFS_WARN         8'h00
`define OFS_LIN          8'h04
`define OFS_LIN_EXT      8'h08
`define OFS_LOUT         8'h0C
`define OFS_LOUT_EXT     8'h10
`define OFS_HOST_POS     8'h14
`define OFS_CMD_POS      8'h18
`define OFS_DEVIATION    8'h1C
`define OFS_CTRL         8'h20
`define OFS_IRQ_STAT     8'h24
`define OFS_IRQ_MASK     8'h28

// Warning word: byte 12 in bits 7:0, byte 13 in 15:8, byte 14 in 23:16
`define WB_OVERLOAD      7
`define WB_FAN_LOCK      6
`define WB_REGEN         5
`define WB_BATTERY       0
`define WB_MAIN_OFF      12
`define WB_UPD_CNT       11
`define WB_CUM_COMM      10
`define WB_CONT_COMM     9
`define WB_SCALE_ERR     8
`define WB_SCALE_COMM    20
`define WB_OSC_DET       19
`define WB_ENC_COMM      18
`define WB_ENC_HOT       17
`define WB_LIFETIME      16

// Logical input word
`define LI_ESTOP         7
`define LI_POS_INHIBIT   3
`define LI_NEG_INHIBIT   2
`define LI_SERVO_ON      0
`define LI_SAFETY_TWO    28
`define LI_SAFETY_ONE    27

// Logical input word, extended
`define LX_NEAR_HOME     4
`define LX_LATCH_LSB     0
`define LX_GP_MON_LSB    18

// Logical output word
`define LO_LOW_LSB       0
`define LO_SPEED_REACHED 9
`define LO_SERVO_ON_N    15
`define LO_HIGH_LSB      16
`define LO_NET_OP_LSB    24

// Logical output word, extended
`define LOX_SYNC_DONE    9

// Control register
`define CTRL_SERVO_ON    0
`define CTRL_MODE_LSB    1
`define MODE_POSITION    2'h0
`define MODE_VELOCITY    2'h1
`define MODE_TORQUE      2'h2

// Interrupt status bits
`define IRQ_WARN         0
`define IRQ_ALARM        1
`define IRQ_SYNC_LOST    2
`define IRQ_INHIBIT      3
`define IRQ_W            4

`define ZERO32           32'h0000_0000
`define CTRL_RESET       3'h0
`endif

// ### logic/bit_sync.v
// Purpose: Two-stage synchroniser for a vector of slow levels
// Assumes: Each bit is an independent level
// Notes:   Stage one is read by stage two only
`timescale 1ns/1ps
module bit_sync #(
    parameter WIDTH = 1
) (
    input  wire             sys_clk_in,
    input  wire             reset_n_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] stable_reg;

    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            meta_reg   <= {WIDTH{1'b0}};
            stable_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg   <= async_in;
            stable_reg <= meta_reg;
        end
    end

    assign sync_out = stable_reg;
endmodule

// ### verif/host_model.sv
// Purpose: Host side of the plain register port
// Assumes: Read data stand one cycle after the read strobe
// Notes:   One access at a time, a gap cycle between accesses
`timescale 1ns/1ps
module host_model (
    input  wire logic        sys_clk_in,
    input  wire logic [31:0] rd_data_in,
    output logic      [7:0]  addr_out = 8'h00,
    output logic      [31:0] data_out = 32'h0000_0000,
    output logic             wr_out   = 1'b0,
    output logic             rd_out   = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        data_out <= d;
        wr_out   <= 1'b1;
        @(posedge sys_clk_in);
        wr_out   <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge sys_clk_in);
        rd_out   <= 1'b0;
        // Data valid only in this cycle
        #1;
        d = rd_data_in;
    endtask
endmodule

// ### verif/packer_asserts.sv
// Purpose: Port checks for the status word packer
// Assumes: Register writes tracked from the strobe port
// Notes:   Estop held low before the host position check
`timescale 1ns/1ps
`include "status_packer_defines.vh"
module packer_asserts #(
    parameter POS_W = 32
) (
    input wire             sys_clk_in,
    input wire             reset_n_in,
    input wire [7:0]       addr_in,
    input wire [31:0]      wr_data_in,
    input wire             wr_en_in,
    input wire             rd_en_in,
    input wire [31:0]      rd_data_out,
    input wire             irq_out,
    input wire             servo_on_cmd_out,
    input wire [POS_W-1:0] cmd_position_out,
    input wire [3:0]       warn_byte12_in,
    input wire [4:0]       warn_byte13_in,
    input wire [4:0]       warn_byte14_in,
    input wire             estop_in,
    input wire [POS_W-1:0] actual_position_in
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    reg  [2:0]       ctrl_reg;
    reg  [POS_W-1:0] host_reg;
    reg  [3:0]       mask_reg;
    wire [23:0]      warn_exp = {3'h0, warn_byte14_in, 3'h0, warn_byte13_in,
                                 warn_byte12_in[3:1], 4'h0, warn_byte12_in[0]};
    wire             vt = ctrl_reg[2:1] == `MODE_VELOCITY ||
                          ctrl_reg[2:1] == `MODE_TORQUE;
    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            ctrl_reg <= 3'h0;
            host_reg <= {POS_W{1'b0}};
            mask_reg <= 4'h0;
        end else if (wr_en_in) begin
            if (addr_in == `OFS_CTRL) ctrl_reg <= wr_data_in[2:0];
            if (addr_in == `OFS_HOST_POS) host_reg <= wr_data_in[POS_W-1:0];
            if (addr_in == `OFS_IRQ_MASK) mask_reg <= wr_data_in[3:0];
        end
    end
    function automatic [31:0] used(input [7:0] a);
        case (a)
            `OFS_WARN:     used = 32'h001F_1FE1;
            `OFS_LIN:      used = 32'h1800_008D;
            `OFS_LIN_EXT:  used = 32'h007C_0017;
            `OFS_LOUT:     used = 32'h03FF_827F;
            `OFS_LOUT_EXT: used = 32'h0000_0200;
            `OFS_CTRL:     used = 32'h0000_0007;
            `OFS_IRQ_STAT, `OFS_IRQ_MASK: used = 32'h0000_000F;
            `OFS_HOST_POS, `OFS_CMD_POS, `OFS_DEVIATION: used = 32'hFFFF_FFFF;
            default:       used = 32'h0000_0000;
        endcase
    endfunction
    property p_rd_idle;
        !rd_en_in |=> rd_data_out == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unused;
        rd_en_in |=> (rd_data_out & ~used($past(addr_in))) == 32'h0000_0000;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");
    property p_warn;
        ($stable(warn_exp))[*4] ##0 (rd_en_in && addr_in == `OFS_WARN)
            |=> rd_data_out[23:0] == $past(warn_exp);
    endproperty
    a_warn: assert property (p_warn) else $error("warning bytes wrong");
    property p_lin0;
        ($stable(servo_on_cmd_out))[*3] ##0 (rd_en_in && addr_in == `OFS_LIN)
            |=> rd_data_out[0] == $past(servo_on_cmd_out);
    endproperty
    a_lin0: assert property (p_lin0) else $error("input bit 0 wrong");
    property p_lout15;
        ($stable(servo_on_cmd_out))[*3] ##0 (rd_en_in && addr_in == `OFS_LOUT)
            |=> rd_data_out[15] == !$past(servo_on_cmd_out);
    endproperty
    a_lout15: assert property (p_lout15) else $error("bit 15 wrong");
    // Gate on the output too: it may lag the control write
    property p_follow;
        (!ctrl_reg[0] && !servo_on_cmd_out) || vt
            |=> cmd_position_out == $past(actual_position_in);
    endproperty
    a_follow: assert property (p_follow) else $error("no tracking");
    property p_host;
        (!estop_in)[*3] ##0 (ctrl_reg[0] && servo_on_cmd_out && !vt)
            |=> cmd_position_out == $past(host_reg);
    endproperty
    a_host: assert property (p_host) else $error("host position lost");
    property p_mask;
        mask_reg == 4'h0 && $past(mask_reg) == 4'h0 |-> !irq_out;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq high");
    c_lout: cover property (rd_en_in && addr_in == `OFS_LOUT);
    c_vel: cover property (vt && servo_on_cmd_out);
    c_irq: cover property ($rose(irq_out));
endmodule
bind servo_status_word_packer packer_asserts #(.POS_W(POS_W)) packer_asserts_inst (
    .sys_clk_in, .reset_n_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
    .rd_data_out, .irq_out, .servo_on_cmd_out, .cmd_position_out,
    .warn_byte12_in, .warn_byte13_in, .warn_byte14_in, .estop_in,
    .actual_position_in);

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the status word packer
// Assumes: Flag pins packed into one vector, three edges to the words
// Notes:   Table rows first, then servo, position and interrupt cases
`timescale 1ns/1ps
`include "status_packer_defines.vh"
module tb_top;
    logic        sys_clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  addr;
    logic [31:0] wdata, rd_data, rv, cmd_pos;
    logic        wr_en, rd_en, irq, son;
    logic [31:0] apos = 32'h0000_0000;
    logic [46:0] pins = 47'h0;
    int          bad_count = 0;
    int          samples_checked = 0;
    logic [46:0] pin_t [4] = '{47'h0, 47'h7FFF_FFFF_FFFF,
                               47'h5555_5555_5555, 47'h2AAA_AAAA_AAAA};
    logic [31:0] exp_t [4][5] = '{
        '{32'h0, 32'h0, 32'h0, 32'h0000_8000, 32'h0},
        '{32'h001F_1FE1, 32'h1800_008C, 32'h007C_0017, 32'h03FF_827F,
          32'h0000_0200},
        '{32'h000A_15A0, 32'h1000_0084, 32'h0028_0005, 32'h02AA_8055,
          32'h0000_0200},
        '{32'h0015_0A41, 32'h0800_0008, 32'h0054_0012, 32'h0155_822A,
          32'h0}};
    host_model host_model_inst (.sys_clk_in(sys_clk_in), .rd_data_in(rd_data),
        .addr_out(addr), .data_out(wdata), .wr_out(wr_en), .rd_out(rd_en));
    servo_status_word_packer servo_status_word_packer_inst (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .addr_in(addr),
        .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .rd_data_out(rd_data), .irq_out(irq), .servo_on_cmd_out(son),
        .cmd_position_out(cmd_pos), .warn_byte12_in(pins[46:43]),
        .warn_byte13_in(pins[42:38]), .warn_byte14_in(pins[37:33]),
        .estop_in(pins[32]), .positive_drive_inhibit_in(pins[31]),
        .negative_drive_inhibit_in(pins[30]), .safety_in_one_in(pins[29]),
        .safety_in_two_in(pins[28]), .near_home_in(pins[27]),
        .latch_in(pins[26:24]), .gp_monitor_in(pins[23:19]),
        .out_low_in(pins[18:12]), .speed_reached_in(pins[11]),
        .out_high_in(pins[10:3]), .net_operation_in(pins[2:1]),
        .link_sync_done_in(pins[0]), .actual_position_in(apos));
    initial begin
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        host_model_inst.rd(a, rv);
        chk($sformatf("reg %h", a), e, rv);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    initial begin
        tick(4);
        reset_n_in <= 1'b1;
        foreach (pin_t[i]) begin
            pins <= pin_t[i];
            tick(4);
            for (int k = 0; k < 5; k++) begin
                rdchk(8'(4 * k), exp_t[i][k]);
            end
            $display("row %0d done", i);
        end
        pins <= 47'h0;
        apos <= 32'h0000_0099;
        host_model_inst.wr(`OFS_HOST_POS, 32'h0000_1234);
        host_model_inst.wr(`OFS_CTRL, 32'h0000_0001);
        tick(4);
        rdchk(`OFS_LIN, 32'h0000_0001);
        rdchk(`OFS_LOUT, 32'h0000_0000);
        chk("cmd pos", 32'h0000_1234, cmd_pos);
        rdchk(`OFS_DEVIATION, 32'h0000_119B);
        // Estop drops the internal command although control asks for on
        pins[32] <= 1'b1;
        tick(5);
        rdchk(`OFS_LIN, 32'h0000_0080);
        pins[32] <= 1'b0;
        for (int m = 0; m < 3; m++) begin
            host_model_inst.wr(`OFS_CTRL, m == 0 ? 32'h0 : 32'((m << 1) | 1));
            repeat (3) begin
                apos <= apos + 32'h0000_0111;
                tick(3);
                chk("cmd pos", apos, cmd_pos);
            end
            rdchk(`OFS_DEVIATION, 32'h0000_0000);
        end
        $display("servo done");
        host_model_inst.wr(8'h40, 32'hFFFF_FFFF);
        host_model_inst.wr(`OFS_WARN, 32'hFFFF_FFFF);
        rdchk(8'h40, 32'h0000_0000);
        rdchk(`OFS_WARN, 32'h0000_0000);
        host_model_inst.rd(`OFS_IRQ_STAT, rv);
        host_model_inst.wr(`OFS_IRQ_MASK, 32'h0000_0001);
        pins[43] <= 1'b1;
        tick(5);
        chk("irq", 32'h1, {31'h0, irq});
        rdchk(`OFS_IRQ_STAT, 32'h0000_0001);
        tick(1);
        chk("irq", 32'h0, {31'h0, irq});
        // Alarm event with its mask bit clear
        pins[13] <= 1'b1;
        tick(5);
        chk("irq", 32'h0, {31'h0, irq});
        rdchk(`OFS_IRQ_STAT, 32'h0000_0002);
        $display("irq done");
        end_sim;
    end
    initial begin
        #100000;
        bad_count++;
        end_sim;
    end
endmodule
